// >>> design/srp_pkg.sv
/*
 * Constants, encodings and tables of the serial print-only reporter.
 * Assumes one 40 MHz core clock and an 8-bit local register port.
 */
package srp_pkg;

    // Clock and oversampling.
    localparam longint unsigned CLK_HZ = 40_000_000;
    localparam int unsigned OVS = 16;

    // Selectable baud rates by index; index 7 repeats the fastest.
    localparam longint unsigned BAUD_RATE [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 19200};

    // Reading cadences in readings per kilosecond: slow, medium, fast, frequency.
    localparam longint unsigned READS_PER_KS [4] = '{2500, 20000, 100000, 4000};

    // Commit key hold time in milliseconds.
    localparam longint unsigned HOLD_MS = 2000;
    localparam longint unsigned HOLD_CYC_DEF = CLK_HZ * HOLD_MS / 1000;

    // Cadence index values.
    localparam logic [1:0] CAD_SLOW = 2'h0;
    localparam logic [1:0] CAD_MED = 2'h1;
    localparam logic [1:0] CAD_FAST = 2'h2;
    localparam logic [1:0] CAD_FREQ = 2'h3;

    // Measurement function codes.
    localparam logic [1:0] FN_NORMAL = 2'h0;
    localparam logic [1:0] FN_FREQ = 2'h1;
    localparam logic [1:0] FN_DIODE = 2'h2;

    // Parity codes.
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;

    // Register offsets.
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_PSEL = 8'h04;
    localparam logic [7:0] REG_PRATE = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_MEAS = 8'h10;

    // Link configuration fields and the measurement function field.
    localparam int CFG_BAUD_LSB = 0;
    localparam int CFG_D8_BIT = 3;
    localparam int CFG_PAR_LSB = 4;
    localparam int CFG_STOP2_BIT = 6;
    localparam int CFG_ECHO_BIT = 7;
    localparam int MEAS_FN_LSB = 2;

    // Reset values.
    localparam logic [7:0] CFG_RST = 8'h05;
    localparam logic [3:0] PRATE_RST = 4'h0;
    localparam logic [3:0] MEAS_RST = 4'h0;

    // Print rates by index.
    localparam logic [15:0] PRATE_TAB [16] = '{
        16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h000a, 16'h0014, 16'h0032, 16'h0064,
        16'h00c8, 16'h01f4, 16'h03e8, 16'h07d0, 16'h1388, 16'h2710, 16'h4e20, 16'hc350};

    // Line characters.
    localparam logic [7:0] CH_SEP = 8'h2c;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [3:0] LN_SEP = 4'h4;
    localparam logic [3:0] LN_CR = 4'h9;
    localparam logic [3:0] LN_LF = 4'ha;

    // Serial frame states.
    typedef enum logic [4:0] {
        SER_IDLE = 5'b00001,
        SER_START = 5'b00010,
        SER_DATA = 5'b00100,
        SER_PAR = 5'b01000,
        SER_STOP = 5'b10000
    } srp_ser_st_t;

    // Oversample divider defaults per baud index.
    function automatic logic [7:0][17:0] srp_baud_divs();
        logic [7:0][17:0] d;
        d = '0;
        for (int i = 0; i < 8; i++) begin
            d[i] = 18'(CLK_HZ / (OVS * BAUD_RATE[i]));
        end
        return d;
    endfunction

    // Reading cadence divider defaults per cadence index.
    function automatic logic [3:0][23:0] srp_read_divs();
        logic [3:0][23:0] d;
        d = '0;
        for (int i = 0; i < 4; i++) begin
            d[i] = 24'(CLK_HZ * 1000 / READS_PER_KS[i]);
        end
        return d;
    endfunction

endpackage

// >>> design/srp_reporter.sv
/*
 * Print-only reporter: register port, cadence, print counter, lines, echo.
 * Assumes engine and panel on core_clk; key and receive pin asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module srp_reporter #(
    parameter logic [7:0][17:0] BAUD_DIV = srp_pkg::srp_baud_divs(),
    parameter logic [3:0][23:0] READ_DIV = srp_pkg::srp_read_divs(),
    parameter logic [26:0] HOLD_CYC = 27'(srp_pkg::HOLD_CYC_DEF)
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic serial_sel,
    input wire logic commit_key,
    input wire logic nv_valid,
    input wire logic [7:0] nv_cfg_in,
    output logic [7:0] nv_cfg_out,
    output logic read_req,
    input wire logic read_done,
    input wire logic [15:0] read_pri,
    input wire logic [15:0] read_sec,
    input wire logic sec_active,
    input wire logic rxd,
    output logic txd,
    output logic cmd_valid,
    output logic [7:0] cmd_data,
    output logic cmd_ferr,
    output logic list_active,
    output logic print_active
);
    import srp_pkg::*;

    typedef struct packed {
        logic [7:0] cfg;
        logic [3:0] psel;
        logic [3:0] prate;
        logic [3:0] meas;
        logic list;
        logic nv_done;
        logic [7:0] rdata;
        logic [17:0] bcnt;
        logic tick;
        logic [23:0] rcnt;
        logic rreq;
        logic k1;
        logic k2;
        logic [26:0] hcnt;
        logic held;
        logic [15:0] ncnt;
        logic ln_pend;
        logic [15:0] pp;
        logic [15:0] ps;
        logic ptwo;
        logic ln_busy;
        logic [3:0] ln_idx;
        logic [15:0] lp;
        logic [15:0] ls;
        logic ltwo;
        logic echo_pend;
        logic [7:0] echo_byte;
        logic tx_start;
        logic [7:0] tx_data;
    } srp_top_t;

    srp_top_t q_r, q_nxt;
    logic tx_busy;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ferr;
    logic [1:0] cad;
    logic [15:0] nval;
    logic tx_ready;
    logic [7:0] ln_char;
    logic [3:0] ln_next;

    // Hex digit of a nibble as an ASCII character.
    function automatic logic [7:0] srp_hex(input logic [3:0] v);
        return (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h57 + {4'h0, v});
    endfunction

    // Character of the output line at a given position.
    function automatic logic [7:0] srp_line_char(input logic [3:0] idx, input logic [15:0] p,
                                                 input logic [15:0] s);
        logic [7:0] c;
        c = CH_LF;
        unique case (idx)
            4'h0: c = srp_hex(p[15:12]);
            4'h1: c = srp_hex(p[11:8]);
            4'h2: c = srp_hex(p[7:4]);
            4'h3: c = srp_hex(p[3:0]);
            4'h4: c = CH_SEP;
            4'h5: c = srp_hex(s[15:12]);
            4'h6: c = srp_hex(s[11:8]);
            4'h7: c = srp_hex(s[7:4]);
            4'h8: c = srp_hex(s[3:0]);
            4'h9: c = CH_CR;
            default: c = CH_LF;
        endcase
        return c;
    endfunction

    // Main control: register port, cadence, counting, formatting and echo.
    always_comb begin
        q_nxt = q_r;
        q_nxt.tick = 1'b0;
        q_nxt.rreq = 1'b0;
        q_nxt.tx_start = 1'b0;
        q_nxt.rdata = 8'h00;

        // The nonvolatile image replaces factory link settings once after reset.
        if (!q_r.nv_done) begin
            q_nxt.nv_done = 1'b1;
            if (nv_valid) begin
                q_nxt.cfg = nv_cfg_in;
            end
        end

        // Register writes come only from the local panel port.
        if (reg_wr) begin
            unique case (reg_addr)
                REG_CFG: q_nxt.cfg = reg_wdata;
                REG_PSEL: begin
                    if (serial_sel) begin
                        q_nxt.psel = reg_wdata[3:0];
                        q_nxt.list = 1'b1;
                    end
                end
                REG_MEAS: q_nxt.meas = reg_wdata[3:0];
                default: ;
            endcase
        end

        // Register reads answer one cycle later; unmapped offsets read zero.
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CFG: q_nxt.rdata = q_r.cfg;
                REG_PSEL: q_nxt.rdata = {4'h0, q_r.psel};
                REG_PRATE: q_nxt.rdata = {4'h0, q_r.prate};
                REG_STAT: q_nxt.rdata = {2'h0, serial_sel, q_r.list, q_r.echo_pend,
                                         q_r.ln_pend, q_r.ln_busy, tx_busy};
                REG_MEAS: q_nxt.rdata = {4'h0, q_r.meas};
                default: q_nxt.rdata = 8'h00;
            endcase
        end

        // Leaving serial selection closes the print-rate list.
        if (!serial_sel) begin
            q_nxt.list = 1'b0;
        end

        // Oversample tick for the selected baud rate.
        if (q_r.bcnt >= BAUD_DIV[q_r.cfg[CFG_BAUD_LSB +: 3]] - 18'h1) begin
            q_nxt.bcnt = 18'h0;
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.bcnt = q_r.bcnt + 18'h1;
        end

        // Reading request cadence from rate and function.
        if (q_r.rcnt >= READ_DIV[cad] - 24'h1) begin
            q_nxt.rcnt = 24'h0;
            q_nxt.rreq = 1'b1;
        end else begin
            q_nxt.rcnt = q_r.rcnt + 24'h1;
        end

        // Commit key: synchronised, then a two-second hold commits once.
        q_nxt.k1 = commit_key;
        q_nxt.k2 = q_r.k1;
        if (!q_r.k2) begin
            q_nxt.hcnt = 27'h0;
            q_nxt.held = 1'b0;
        end else if (!q_r.held) begin
            if (q_r.hcnt >= HOLD_CYC - 27'h1) begin
                q_nxt.held = 1'b1;
                if (q_r.list && serial_sel) begin
                    q_nxt.prate = q_r.psel;
                    q_nxt.list = 1'b0;
                    q_nxt.ncnt = 16'h0;
                end
            end else begin
                q_nxt.hcnt = q_r.hcnt + 27'h1;
            end
        end

        // Count displayed readings; every N-th is latched for printing.
        if (nval == 16'h0) begin
            q_nxt.ncnt = 16'h0;
        end else if (read_done && q_nxt.ncnt == q_r.ncnt) begin
            if (q_r.ncnt >= nval - 16'h1) begin
                q_nxt.ncnt = 16'h0;
                q_nxt.ln_pend = 1'b1;
                q_nxt.pp = read_pri;
                q_nxt.ps = read_sec;
                q_nxt.ptwo = sec_active;
            end else begin
                q_nxt.ncnt = q_r.ncnt + 16'h1;
            end
        end

        // Received characters are held for echo only when echo is on.
        if (rx_valid && q_r.cfg[CFG_ECHO_BIT]) begin
            q_nxt.echo_pend = 1'b1;
            q_nxt.echo_byte = rx_data;
        end

        // Transmit arbitration: a started line owns the link until its LF.
        if (tx_ready) begin
            if (q_r.ln_busy) begin
                q_nxt.tx_start = 1'b1;
                q_nxt.tx_data = ln_char;
                q_nxt.ln_idx = ln_next;
                if (q_r.ln_idx == LN_LF) begin
                    q_nxt.ln_busy = 1'b0;
                end
            end else if (q_r.ln_pend && !(read_done && q_nxt.ln_pend && q_nxt.pp != q_r.pp)) begin
                q_nxt.ln_pend = q_nxt.ln_pend && (q_nxt.pp != q_r.pp);
                q_nxt.ln_busy = 1'b1;
                q_nxt.ln_idx = 4'h0;
                q_nxt.lp = q_r.pp;
                q_nxt.ls = q_r.ps;
                q_nxt.ltwo = q_r.ptwo;
            end else if (q_r.echo_pend) begin
                q_nxt.tx_start = 1'b1;
                q_nxt.tx_data = q_r.echo_byte;
                q_nxt.echo_pend = rx_valid && q_r.cfg[CFG_ECHO_BIT];
            end
        end
    end

    // Cadence index: frequency fixes four per second, diode forces fast.
    always_comb begin
        unique case (q_r.meas[MEAS_FN_LSB +: 2])
            FN_FREQ: cad = CAD_FREQ;
            FN_DIODE: cad = CAD_FAST;
            default: cad = (q_r.meas[1:0] == CAD_FREQ) ? CAD_FAST : q_r.meas[1:0];
        endcase
    end

    // Derived line and transmit controls.
    always_comb begin
        nval = PRATE_TAB[q_r.prate];
        tx_ready = !tx_busy && !q_r.tx_start;
        ln_char = srp_line_char(q_r.ln_idx, q_r.lp, q_r.ls);
        if (q_r.ln_idx == 4'h3 && !q_r.ltwo) begin
            ln_next = LN_CR;
        end else begin
            ln_next = q_r.ln_idx + 4'h1;
        end
    end

    // State register; link settings start at factory defaults.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '{cfg: CFG_RST, prate: PRATE_RST, psel: PRATE_RST, meas: MEAS_RST,
                     default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // Serial transmitter.
    srp_uart_tx u_tx (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(q_r.tick),
        .start(q_r.tx_start),
        .data(q_r.tx_data),
        .d8(q_r.cfg[CFG_D8_BIT]),
        .parity(q_r.cfg[CFG_PAR_LSB +: 2]),
        .stop2(q_r.cfg[CFG_STOP2_BIT]),
        .busy(tx_busy),
        .txd(txd)
    );

    // Serial receiver; its output reaches only the command port and echo.
    srp_uart_rx u_rx (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(q_r.tick),
        .rxd(rxd),
        .d8(q_r.cfg[CFG_D8_BIT]),
        .hp(!q_r.cfg[CFG_D8_BIT] || (q_r.cfg[CFG_PAR_LSB +: 2] != PAR_NONE)),
        .valid(rx_valid),
        .data(rx_data),
        .ferr(rx_ferr)
    );

    // Outputs.
    assign reg_rdata = q_r.rdata;
    assign nv_cfg_out = q_r.cfg;
    assign read_req = q_r.rreq;
    assign cmd_valid = rx_valid;
    assign cmd_data = rx_data;
    assign cmd_ferr = rx_ferr;
    assign list_active = q_r.list;
    assign print_active = (q_r.prate != 4'h0);
endmodule
`default_nettype wire

// >>> design/srp_uart_rx.sv
/*
 * Serial character receiver with a two-stage pin synchroniser, mid-bit
 * sampling and a stop-bit check.
 * Assumes a one-cycle tick at sixteen times the baud rate.
 */
`timescale 1ns/1ps
`default_nettype none
module srp_uart_rx (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic rxd,
    input wire logic d8,
    input wire logic hp,
    output logic valid,
    output logic [7:0] data,
    output logic ferr
);
    import srp_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        srp_ser_st_t st;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic [3:0] sub;
        logic valid;
        logic [7:0] data;
        logic ferr;
    } srp_rx_t;

    srp_rx_t q_r, q_nxt;
    logic samp;

    // Synchroniser, start detection and mid-bit sampling.
    always_comb begin
        q_nxt = q_r;
        q_nxt.s1 = rxd;
        q_nxt.s2 = q_r.s1;
        q_nxt.valid = 1'b0;
        samp = tick && (q_r.sub == 4'hf);
        if (tick) begin
            q_nxt.sub = q_r.sub + 4'h1;
        end
        unique case (q_r.st)
            SER_IDLE: begin
                q_nxt.sub = 4'h0;
                if (!q_r.s2) begin
                    q_nxt.st = SER_START;
                end
            end
            SER_START: begin
                if (tick && q_r.sub == 4'h7) begin
                    q_nxt.sub = 4'h0;
                    q_nxt.cnt = 3'h0;
                    q_nxt.st = q_r.s2 ? SER_IDLE : SER_DATA;
                end
            end
            SER_DATA: begin
                if (samp) begin
                    q_nxt.sh = {q_r.s2, q_r.sh[7:1]};
                    q_nxt.cnt = q_r.cnt + 3'h1;
                    if (q_r.cnt == (d8 ? 3'h7 : 3'h6)) begin
                        q_nxt.st = hp ? SER_PAR : SER_STOP;
                    end
                end
            end
            SER_PAR: begin
                if (samp) begin
                    q_nxt.st = SER_STOP;
                end
            end
            SER_STOP: begin
                if (samp) begin
                    q_nxt.st = SER_IDLE;
                    q_nxt.valid = 1'b1;
                    q_nxt.ferr = !q_r.s2;
                    q_nxt.data = d8 ? q_r.sh : {1'b0, q_r.sh[7:1]};
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '{s1: 1'b1, s2: 1'b1, st: SER_IDLE, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign valid = q_r.valid;
    assign data = q_r.data;
    assign ferr = q_r.ferr;
endmodule
`default_nettype wire

// >>> design/srp_uart_tx.sv
/*
 * Serial character transmitter: start bit, seven or eight data bits, optional
 * parity position, one or two stop bits.
 * Assumes a one-cycle tick at sixteen times the baud rate.
 */
`timescale 1ns/1ps
`default_nettype none
module srp_uart_tx (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic [7:0] data,
    input wire logic d8,
    input wire logic [1:0] parity,
    input wire logic stop2,
    output logic busy,
    output logic txd
);
    import srp_pkg::*;

    typedef struct packed {
        srp_ser_st_t st;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic [3:0] sub;
        logic par;
        logic hp;
        logic d8;
        logic two;
        logic line;
    } srp_tx_t;

    srp_tx_t q_r, q_nxt;
    logic bit_end;
    logic [7:0] bits;

    // Frame sequencer; parity, width and parity slot are latched at start, the stop count at the last data or parity bit.
    always_comb begin
        q_nxt = q_r;
        bits = d8 ? data : {1'b0, data[6:0]};
        bit_end = tick && (q_r.sub == 4'hf);
        if (tick) begin
            q_nxt.sub = q_r.sub + 4'h1;
        end
        unique case (q_r.st)
            SER_IDLE: begin
                q_nxt.sub = 4'h0;
                q_nxt.line = 1'b1;
                if (start) begin
                    q_nxt.st = SER_START;
                    q_nxt.sh = bits;
                    q_nxt.d8 = d8;
                    q_nxt.hp = !d8 || (parity != PAR_NONE);
                    q_nxt.par = (parity == PAR_EVEN) ? ^bits : (parity == PAR_ODD) ? ~^bits : 1'b0;
                    q_nxt.line = 1'b0;
                end
            end
            SER_START: begin
                if (bit_end) begin
                    q_nxt.st = SER_DATA;
                    q_nxt.cnt = 3'h0;
                    q_nxt.line = q_r.sh[0];
                end
            end
            SER_DATA: begin
                if (bit_end) begin
                    q_nxt.sh = q_r.sh >> 1;
                    q_nxt.line = q_r.sh[1];
                    q_nxt.cnt = q_r.cnt + 3'h1;
                    if (q_r.cnt == (q_r.d8 ? 3'h7 : 3'h6)) begin
                        q_nxt.st = q_r.hp ? SER_PAR : SER_STOP;
                        q_nxt.line = q_r.hp ? q_r.par : 1'b1;
                        q_nxt.two = stop2;
                    end
                end
            end
            SER_PAR: begin
                if (bit_end) begin
                    q_nxt.st = SER_STOP;
                    q_nxt.line = 1'b1;
                    q_nxt.two = stop2;
                end
            end
            SER_STOP: begin
                if (bit_end) begin
                    q_nxt.two = 1'b0;
                    q_nxt.st = q_r.two ? SER_STOP : SER_IDLE;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '{st: SER_IDLE, line: 1'b1, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign busy = (q_r.st != SER_IDLE);
    assign txd = q_r.line;
endmodule
`default_nettype wire

// >>> test/srp_host_model.sv
/* Serial host model: drives rxd and collects txd.
   Assumes 64 core cycles a bit, seven data bits and a zero parity slot. */
`timescale 1ns/1ps
`default_nettype none
module srp_host_model (
    input wire logic core_clk,
    input wire logic txd,
    output var logic rxd
);
    localparam int BIT = 64;
    // The line idles high, driven by the model.
    initial rxd = 1'b1;
    // Sends a start bit, eight slots LSB first and a stop bit.
    task automatic send(input logic [7:0] c);
        @(posedge core_clk);
        rxd <= 1'b0;
        repeat (BIT) @(posedge core_clk);
        for (int b = 0; b < 8; b++) begin
            rxd <= c[b];
            repeat (BIT) @(posedge core_clk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge core_clk);
    endtask
    // Waits for a start bit, samples each slot mid-bit, returns mid-stop.
    task automatic get(output logic [7:0] c);
        int i;
        i = 0;
        while (txd !== 1'b0 && i < 4000) begin
            @(posedge core_clk);
            i++;
        end
        repeat (BIT / 2) @(posedge core_clk);
        for (int b = 0; b < 8; b++) begin
            repeat (BIT) @(posedge core_clk);
            c[b] = txd;
        end
        repeat (BIT) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// >>> test/srp_reporter_properties.sv
/* Port checker for the reporter.
   Assumes reading dividers of at least 10 cycles. */
`timescale 1ns/1ps
`default_nettype none
module srp_reporter_properties (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic serial_sel,
    input wire logic commit_key,
    input wire logic [7:0] nv_cfg_out,
    input wire logic read_req,
    input wire logic cmd_valid,
    input wire logic list_active,
    input wire logic print_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Quiet cycles that follow every reading request.
    sequence s_req_gap; !read_req[*8]; endsequence
    property p_rd_zero; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    property p_req_gap; read_req |=> s_req_gap; endproperty
    property p_cmd_pulse; cmd_valid |=> !cmd_valid; endproperty
    property p_rst_idle; !$past(arst_n) |-> !print_active && !list_active; endproperty
    property p_list_sel; $rose(list_active) |-> $past(serial_sel); endproperty
    property p_cfg_local; $past(arst_n) && !reg_wr |=> $stable(nv_cfg_out); endproperty
    property p_commit; $fell(list_active) |-> $past(commit_key, 3) && $past(commit_key, 12); endproperty
    property p_prate; $rose(print_active) |-> $past(list_active); endproperty
    // Each check but a_req_gap and a_cmd_pulse ties an output to its cause; those two bound request spacing and strobe width.
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
    a_req_gap: assert property (p_req_gap) else $error("requests too close");
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command strobe long");
    a_rst_idle: assert property (p_rst_idle) else $error("printing after reset");
    a_list_sel: assert property (p_list_sel) else $error("list without serial");
    a_cfg_local: assert property (p_cfg_local) else $error("settings changed");
    a_commit: assert property (p_commit) else $error("commit without hold");
    a_prate: assert property (p_prate) else $error("rate set outside list");
endmodule
`default_nettype wire

// >>> test/srp_reporter_tb.sv
/* Reporter bench: registers, key, printing and echo.
   Assumes the checker and host model. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s %h %h", n, e, g); end end
module srp_reporter_tb;
    import srp_pkg::*;
    logic core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, serial_sel = 1, commit_key = 0;
    logic read_done = 0, sec_active = 0, read_req, rxd, txd, cmd_valid, cmd_ferr, list_active, print_active;
    logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, nv_cfg_out, cmd_data, c;
    logic [15:0] read_pri = '0, read_sec = '0;
    int n_fail = 0, tests_run = 0, cyc = 0, lows;
    string s;
    srp_reporter #(.BAUD_DIV({8{18'd4}}), .READ_DIV({24'd40, 24'd10, 24'd30, 24'd20}), .HOLD_CYC(27'd20)) DUT (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_sel(serial_sel), .commit_key(commit_key),
        .nv_valid(1'b0), .nv_cfg_in(8'h00), .nv_cfg_out(nv_cfg_out), .read_req(read_req), .read_done(read_done),
        .read_pri(read_pri), .read_sec(read_sec), .sec_active(sec_active), .rxd(rxd), .txd(txd),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ferr(cmd_ferr), .list_active(list_active),
        .print_active(print_active));
    srp_host_model host (.core_clk(core_clk), .txd(txd), .rxd(rxd));
    // Clock and hang guard.
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    // Register port cycles and a completed-reading strobe.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK("rdata", e, reg_rdata)
    endtask
    task rdg(input logic [15:0] p);
        @(posedge core_clk);
        read_done <= 1'b1;
        read_pri <= p;
        @(posedge core_clk);
        read_done <= 1'b0;
    endtask
    task t_reset;
        rd(REG_CFG, CFG_RST);
        rd(REG_PRATE, 8'h00);
        rd(8'h14, 8'h00);
        `CHK("print", 1'b0, print_active)
        $display("reset done");
    endtask
    task t_list;
        @(posedge core_clk) serial_sel <= 1'b0;
        wr(REG_PSEL, 8'h02);
        #1 `CHK("list", 1'b0, list_active)
        @(posedge core_clk) serial_sel <= 1'b1;
        wr(REG_PSEL, 8'h02);
        #1 `CHK("list", 1'b1, list_active)
        $display("list done");
    endtask
    task t_commit;
        @(posedge core_clk) commit_key <= 1'b1;
        repeat (10) @(posedge core_clk);
        commit_key <= 1'b0;
        repeat (30) @(posedge core_clk);
        #1 `CHK("list", 1'b1, list_active)
        @(posedge core_clk) commit_key <= 1'b1;
        repeat (30) @(posedge core_clk);
        commit_key <= 1'b0;
        #1 `CHK("list", 1'b0, list_active)
        `CHK("print", 1'b1, print_active)
        rd(REG_PRATE, 8'h02);
        $display("commit done");
    endtask
    task t_print;
        @(posedge core_clk);
        read_sec <= 16'h00c5;
        sec_active <= 1'b1;
        rdg(16'h1111);
        rdg(16'h1a2b);
        s = $sformatf("%04h,%04h\r\n", 16'h1a2b, 16'h00c5);
        for (int i = 0; i < 11; i++) begin
            host.get(c);
            `CHK("char", s[i], c)
        end
        $display("print done");
    endtask
    task t_echo;
        lows = 0;
        fork
            host.send(8'h41);
            repeat (800) @(posedge core_clk) lows += (txd === 1'b0);
        join
        `CHK("quiet", 0, lows)
        `CHK("cmd", 8'h41, cmd_data)
        `CHK("ferr", 1'b0, cmd_ferr)
        wr(REG_CFG, 8'h85);
        fork
            host.send(8'h42);
            host.get(c);
        join
        `CHK("echo", 8'h42, c)
        rd(REG_CFG, 8'h85);
        $display("echo done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset;
        t_list;
        t_commit;
        t_print;
        t_echo;
        stop_test;
    end
endmodule
bind srp_reporter srp_reporter_properties u_chk (.core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_sel(serial_sel), .commit_key(commit_key),
    .nv_cfg_out(nv_cfg_out), .read_req(read_req), .cmd_valid(cmd_valid), .list_active(list_active),
    .print_active(print_active));
`default_nettype wire
